// File: ksp_defs.svh
/*
 Constants for the keyboard and system port unit: I/O addresses, control
 bit positions, reset values and receiver framing. Included by bare name.
*/
`ifndef KSP_DEFS_SVH
`define KSP_DEFS_SVH
`define KSP_ADDR_SCAN 8'h60
`define KSP_ADDR_CTRL 8'h61
`define KSP_ADDR_STAT 8'h62
`define KSP_ADDR_MODE 8'h63
`define KSP_MODE_NORMAL 8'h99
`define KSP_MODE_RESET 8'h9b
`define KSP_CTRL_RESET 8'h00
`define KSP_BYTE_ZERO 8'h00
`define KSP_MODE_MSB 7
`define KSP_MODE_SEL_BIT 7
`define KSP_MODE_A_IN_BIT 4
`define KSP_MODE_GA_HI 6
`define KSP_MODE_GA_LO 5
`define KSP_MODE_GB_BIT 2
`define KSP_MODE_CH_IN_BIT 3
`define KSP_MODE_B_IN_BIT 1
`define KSP_MODE_CL_IN_BIT 0
`define KSP_CB_SPK_GATE 0
`define KSP_CB_SPK_DATA 1
`define KSP_CB_HALF_SEL 2
`define KSP_CB_PAR_DIS 4
`define KSP_CB_CHK_DIS 5
`define KSP_CB_KCLK_EN 6
`define KSP_CB_KCLR 7
`define KSP_ST_COPROC 1
`define KSP_ST_SPARE 4
`define KSP_ST_TIMER2 5
`define KSP_ST_CHAN_CHK 6
`define KSP_ST_PARITY 7
`define KSP_FRAME_BITS 4'h9
`define KSP_CNT_ZERO 4'h0
`define KSP_CNT_ONE 4'h1
`endif

// File: ksp_pkg.sv
/*
 Types for the keyboard and system port unit.
 Assumes ksp_defs.svh is compiled alongside.
*/
package ksp_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } ksp_io_req_t;
   typedef struct packed {
      logic [7:0] scan;
      logic full;
   } ksp_kbd_t;
endpackage

// File: ksp_ports.sv
/*
 Keyboard scan, system control, system status and direction command ports,
 with a serial keyboard receiver on the system clock.
 Assumes host I/O strobes are one-cycle pulses synchronous to i_clk and that
 the keyboard clock and data lines arrive asynchronously.
*/
//
// Operation
// - Basic input/output mode only, no handshake modes
// - Port accesses complete without peripheral handshake
// - Addresses 60h, 61h, 62h select three ports
// - Address 63h selects the direction command register
// - Word 99h: first, third inputs, second output
// - Reading 60h returns assembled scan code
// - Second port controls system, third reports status
// - Shift keyboard data on strobe into byte
// - Complete byte raises keyboard interrupt level one
// - Scan register is read-only to host
// - Control bit 7 clears data and shift registers
// - Keyboard interrupt wired internally, not channel
// - Status port identifies coprocessor, parity, channel check
// - Control bits gate speaker, parity, check, clock
`timescale 1ns/10ps
`include "ksp_defs.svh"
module ksp_ports (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire ksp_pkg::ksp_io_req_t i_io,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   input wire logic i_kbd_serial_strobe,
   input wire logic i_kbd_serial_in,
   input wire logic [3:0] i_config_low,
   input wire logic [3:0] i_config_high,
   input wire logic i_timer2_out,
   input wire logic i_coproc_err,
   input wire logic i_parity_err,
   input wire logic i_channel_check_n,
   output logic o_speaker_gate,
   output logic o_speaker_data,
   output logic o_status_half_select,
   output logic o_parity_check_en,
   output logic o_channel_check_en,
   output logic o_key_byte_irq
);
   logic [7:0] mode;
   logic [7:0] ctrl;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   ksp_pkg::ksp_kbd_t kbd;
   logic [1:0] clk_sync;
   logic [1:0] dat_sync;
   logic clk_prev;
   logic strobe_fall;
   logic kbd_clear;
   logic wr_mode;
   logic wr_ctrl;
   logic [7:0] status_val;
   logic [7:0] next_rdata;
   logic mode_word;
   logic a_in;
   logic b_out;
   logic c_in;
   logic [11:0] stat_meta;
   logic [11:0] stat_sync;
   logic [3:0] cfg_low_s;
   logic [3:0] cfg_high_s;
   logic tmr_s;
   logic cop_s;
   logic par_s;
   logic chk_n_s;

   assign wr_mode = i_io.wr && (i_io.addr == `KSP_ADDR_MODE);
   assign wr_ctrl = i_io.wr && (i_io.addr == `KSP_ADDR_CTRL);
   assign mode_word = mode[`KSP_MODE_SEL_BIT];
   assign a_in = mode[`KSP_MODE_A_IN_BIT];
   assign b_out = !mode[`KSP_MODE_B_IN_BIT];
   assign c_in = mode[`KSP_MODE_CH_IN_BIT] && mode[`KSP_MODE_CL_IN_BIT];

   // Direction command; only mode-set words with group modes zero are taken
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mode <= `KSP_MODE_RESET;
      end else if (wr_mode && i_io.wdata[`KSP_MODE_SEL_BIT]
                   && (i_io.wdata[`KSP_MODE_GA_HI:`KSP_MODE_GA_LO] == 2'h0)
                   && !i_io.wdata[`KSP_MODE_GB_BIT]) begin
         mode <= i_io.wdata;
      end
   end

   // Control port; an input-direction port ignores writes
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl <= `KSP_CTRL_RESET;
      end else if (wr_mode) begin
         ctrl <= `KSP_CTRL_RESET;
      end else if (wr_ctrl && b_out) begin
         ctrl <= i_io.wdata;
      end
   end

   assign o_speaker_gate = ctrl[`KSP_CB_SPK_GATE] && b_out;
   assign o_speaker_data = ctrl[`KSP_CB_SPK_DATA] && b_out;
   assign o_status_half_select = ctrl[`KSP_CB_HALF_SEL];
   assign o_parity_check_en = !ctrl[`KSP_CB_PAR_DIS];
   assign o_channel_check_en = !ctrl[`KSP_CB_CHK_DIS];
   assign kbd_clear = ctrl[`KSP_CB_KCLR];

   // Keyboard line synchronizers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         clk_sync <= 2'b11;
         dat_sync <= 2'b11;
         clk_prev <= 1'b1;
      end else begin
         clk_sync <= {clk_sync[0], i_kbd_serial_strobe};
         dat_sync <= {dat_sync[0], i_kbd_serial_in};
         clk_prev <= clk_sync[1];
      end
   end

   assign strobe_fall = clk_prev && !clk_sync[1] && ctrl[`KSP_CB_KCLK_EN];

   // Receiver: start bit then eight data bits, LSB first
   always_ff @(posedge i_clk) begin
      if (i_reset || kbd_clear) begin
         shift <= `KSP_BYTE_ZERO;
         bit_cnt <= `KSP_CNT_ZERO;
         kbd <= '0;
      end else if (strobe_fall && !kbd.full) begin
         if (bit_cnt == `KSP_CNT_ZERO) begin
            bit_cnt <= dat_sync[1] ? `KSP_CNT_ONE : `KSP_CNT_ZERO;
         end else begin
            shift <= {dat_sync[1], shift[7:1]};
            if (bit_cnt == `KSP_FRAME_BITS - 4'h1) begin
               kbd.scan <= {dat_sync[1], shift[7:1]};
               kbd.full <= 1'b1;
               bit_cnt <= `KSP_CNT_ZERO;
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end
      end
   end

   // Interrupt straight to level one, never to the channel
   assign o_key_byte_irq = kbd.full;

   // Status and strap inputs come from other domains
   always_ff @(posedge i_clk) begin
      stat_meta <= {i_channel_check_n, i_parity_err, i_coproc_err, i_timer2_out, i_config_high, i_config_low};
      stat_sync <= stat_meta;
   end

   assign {chk_n_s, par_s, cop_s, tmr_s, cfg_high_s, cfg_low_s} = stat_sync;

   // Status port, bits 7:5 from hardware sources, bit 4 zero, lower half by select, coprocessor ORed into bit 1 when low half selected
   always_comb begin
      status_val[3:0] = ctrl[`KSP_CB_HALF_SEL] ? cfg_high_s : cfg_low_s;
      status_val[`KSP_ST_SPARE] = 1'h0;
      status_val[`KSP_ST_TIMER2] = tmr_s;
      status_val[`KSP_ST_CHAN_CHK] = !chk_n_s && o_channel_check_en;
      status_val[`KSP_ST_PARITY] = par_s && o_parity_check_en;
      if (ctrl[`KSP_CB_HALF_SEL] == 1'h0) begin
         status_val[`KSP_ST_COPROC] = cfg_low_s[`KSP_ST_COPROC] | cop_s;
      end
   end

   // Host reads; the scan register has no write path
   always_comb begin
      next_rdata = `KSP_BYTE_ZERO;
      unique case (i_io.addr)
         `KSP_ADDR_SCAN: next_rdata = a_in ? kbd.scan : `KSP_BYTE_ZERO;
         `KSP_ADDR_CTRL: next_rdata = ctrl;
         `KSP_ADDR_STAT: next_rdata = c_in ? status_val : `KSP_BYTE_ZERO;
         default: next_rdata = `KSP_BYTE_ZERO;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= `KSP_BYTE_ZERO;
         o_rvalid <= 1'b0;
      end else begin
         o_rdata <= i_io.rd ? next_rdata : o_rdata;
         o_rvalid <= i_io.rd;
      end
   end

   a_irq_on_byte: assert property (@(posedge i_clk) disable iff (i_reset)
      (strobe_fall && !kbd.full && !kbd_clear && bit_cnt == (`KSP_FRAME_BITS - 4'h1)) |=> o_key_byte_irq)
      else $error("byte complete without interrupt");
   a_clear_drops: assert property (@(posedge i_clk) disable iff (i_reset)
      kbd_clear |=> (!o_key_byte_irq && bit_cnt == `KSP_CNT_ZERO && shift == `KSP_BYTE_ZERO))
      else $error("clear bit did not empty receiver");
   a_irq_holds: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_key_byte_irq && !kbd_clear) |=> o_key_byte_irq)
      else $error("interrupt dropped while byte held");
   a_scan_stable: assert property (@(posedge i_clk) disable iff (i_reset)
      o_key_byte_irq && $past(o_key_byte_irq) |-> $stable(kbd.scan))
      else $error("held scan code changed");
   a_read_one: assert property (@(posedge i_clk) disable iff (i_reset)
      i_io.rd |=> o_rvalid)
      else $error("read not answered next cycle");
   a_scan_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_io.rd && i_io.addr == `KSP_ADDR_SCAN && a_in) |=> o_rdata == $past(kbd.scan))
      else $error("scan read wrong");
   a_mode_normal: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr_mode && i_io.wdata == `KSP_MODE_NORMAL) |=> (a_in && b_out && c_in && mode_word))
      else $error("normal word gave wrong directions");
   a_ctrl_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr_ctrl && b_out && !wr_mode) |=> (ctrl == $past(i_io.wdata)))
      else $error("control write lost");
   a_rvalid_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_io.rd |=> !o_rvalid)
      else $error("read answer longer than one cycle");
   a_kclk_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      (!ctrl[`KSP_CB_KCLK_EN] && !kbd_clear) |=> ($stable(bit_cnt) && $stable(kbd)))
      else $error("receiver moved with keyboard clock off");
   a_scan_no_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_io.wr && i_io.addr == `KSP_ADDR_SCAN && !strobe_fall && !kbd_clear) |=> $stable(kbd.scan))
      else $error("host write changed scan code");
endmodule // ksp_ports

// File: ksp_kbd_model.sv
/*
 Keyboard model: one start bit, then eight data bits LSB first.
 Assumes the caller spaces frames; both lines idle high by pull-up.
*/
`timescale 1ns/10ps
module ksp_kbd_model (
   output logic o_strobe,
   output logic o_data
);
   initial begin
      o_strobe = 1'b1;
      o_data = 1'b1;
   end
   // Data changes while the strobe is high
   task automatic send_byte(input logic [7:0] b);
      logic [8:0] f;
      f = {b, 1'b1};
      for (int i = 0; i < 9; i++) begin
         o_data = f[i];
         #400;
         o_strobe = 1'b0;
         #400;
         o_strobe = 1'b1;
      end
      o_data = 1'b1;
   endtask
endmodule // ksp_kbd_model

// File: keyboard_and_system_ports_tb_top.sv
/*
 Testbench for the port unit: host I/O tasks and a keyboard model.
 Assumes ksp_pkg, ksp_ports and ksp_kbd_model are compiled first.
*/
`timescale 1ns/10ps
module keyboard_and_system_ports_tb_top;
   logic clk, rst, rvalid, irq, sg, sd, hs, pe, ce, kstb, kdat, tmr, cop, par, chk_n;
   logic [7:0] rdata;
   logic [3:0] cfg_lo, cfg_hi;
   ksp_pkg::ksp_io_req_t io;
   int num_errors, checks_done;
   ksp_kbd_model kbd (.o_strobe(kstb), .o_data(kdat));
   ksp_ports dut (.i_clk(clk), .i_reset(rst), .i_io(io), .o_rdata(rdata), .o_rvalid(rvalid),
      .i_kbd_serial_strobe(kstb), .i_kbd_serial_in(kdat), .i_config_low(cfg_lo),
      .i_config_high(cfg_hi), .i_timer2_out(tmr), .i_coproc_err(cop), .i_parity_err(par),
      .i_channel_check_n(chk_n), .o_speaker_gate(sg), .o_speaker_data(sd),
      .o_status_half_select(hs), .o_parity_check_en(pe), .o_channel_check_en(ce),
      .o_key_byte_irq(irq));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task give_verdict;
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      io <= {a, d, 2'b01};
      @(posedge clk);
      io <= '0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      io <= {a, 8'h00, 2'b10};
      @(posedge clk);
      io <= '0;
      #1;
      check({7'h00, rvalid}, 8'h01);
      check(rdata, e);
   endtask
   task check_outs(input logic [7:0] e);
      check({3'h0, sg, sd, hs, pe, ce}, e);
   endtask
   task wait_irq(input logic e);
      int n;
      n = 0;
      while (irq !== e && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({7'h00, irq}, {7'h00, e});
      if (irq !== e) give_verdict();
   endtask
   initial begin
      rst = 1'b1;
      io = '0;
      cfg_lo = 4'h4;
      cfg_hi = 4'ha;
      tmr = 1'b1;
      cop = 1'b1;
      par = 1'b1;
      chk_n = 1'b0;
      num_errors = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      check_outs(8'h03);
      check({7'h00, irq}, 8'h00);
      wr(8'h61, 8'h07);
      check_outs(8'h03);
      $display("test reset done");
      wr(8'h63, 8'h99);
      wr(8'h61, 8'h37);
      check_outs(8'h1c);
      wr(8'h63, 8'hbb);
      wr(8'h61, 8'h37);
      check_outs(8'h1c);
      rd(8'h61, 8'h37);
      rd(8'h62, 8'h2a);
      wr(8'h61, 8'h00);
      check_outs(8'h03);
      rd(8'h62, 8'he6);
      @(posedge clk);
      tmr <= 1'h0;
      cop <= 1'h0;
      par <= 1'h0;
      chk_n <= 1'h1;
      repeat (2) @(posedge clk);
      rd(8'h62, 8'h04);
      rd(8'h63, 8'h00);
      rd(8'h64, 8'h00);
      $display("test ports done");
      wr(8'h61, 8'h40);
      kbd.send_byte(8'ha5);
      wait_irq(1'b1);
      rd(8'h60, 8'ha5);
      wr(8'h60, 8'h11);
      rd(8'h60, 8'ha5);
      kbd.send_byte(8'h3c);
      repeat (10) @(posedge clk);
      rd(8'h60, 8'ha5);
      wr(8'h61, 8'hc0);
      wait_irq(1'b0);
      wr(8'h61, 8'h40);
      rd(8'h60, 8'h00);
      kbd.send_byte(8'h3c);
      wait_irq(1'b1);
      rd(8'h60, 8'h3c);
      wr(8'h61, 8'hc0);
      wr(8'h61, 8'h00);
      kbd.send_byte(8'h81);
      repeat (10) @(posedge clk);
      rd(8'h60, 8'h00);
      $display("test keyboard done");
      give_verdict();
   end
endmodule // keyboard_and_system_ports_tb_top
